// File: hw/sfc_pkg.sv
// Purpose: Shared constants and types for the serial flash command front end
// Assumes: System clock of 50 MHz
// Notes: Timing counts are derived from the printed times
package sfc_pkg;

	localparam int SYS_CLK_MHZ = 50;
	// Internal power-on hold, microseconds
	localparam int SUPPLY_TO_SELECT_WAIT_US = 70;
	localparam int SUPPLY_TO_SELECT_WAIT_CYC = SUPPLY_TO_SELECT_WAIT_US * SYS_CLK_MHZ;
	// Delay before the first program or erase, milliseconds
	localparam int FIRST_WRITE_WAIT_MS = 3;
	localparam int FIRST_WRITE_WAIT_CYC = FIRST_WRITE_WAIT_MS * 1000 * SYS_CLK_MHZ;

	// Frame field sizes in bits and address field bit positions
	localparam int OPCODE_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int PAGE_MSB = 21;
	localparam int PAGE_LSB = 10;
	localparam int POS_MSB = 9;
	localparam int D2_DUMMY_BITS = 32;
	localparam int D4_DUMMY_BITS = 8;

	localparam logic [7:0] OP_D1 = 8'hd1;
	localparam logic [7:0] OP_D2 = 8'hd2;
	localparam logic [7:0] OP_D4 = 8'hd4;
	localparam logic [7:0] OP_D6 = 8'hd6;
	localparam logic [7:0] OP_D7 = 8'hd7;

	typedef enum logic [1:0] {
		ST_POR = 2'b00,
		ST_STANDBY = 2'b01,
		ST_SHIFT = 2'b10
	} sfc_state_t;

	typedef enum logic {
		SFC_MODE0 = 1'b0,
		SFC_MODE3 = 1'b1
	} sfc_mode_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [11:0] page_number_bits;
		logic [9:0] byte_position_bits;
	} sfc_cmd_t;

	// Opcodes that carry an address field: all but the listed ones
	function automatic logic has_addr(input logic [7:0] op);
		has_addr = !(op == OP_D7 || op == 8'h9f || op == 8'hb9 || op == 8'hab ||
			op == 8'hb0 || op == 8'hd0 || op == 8'h79);
	endfunction

	// Total header length: opcode, address and dummy bits
	function automatic logic [6:0] hdr_bits(input logic [7:0] op);
		if (!has_addr(op)) begin
			hdr_bits = 7'(OPCODE_BITS);
		end else if (op == OP_D2) begin
			hdr_bits = 7'(OPCODE_BITS + ADDR_BITS + D2_DUMMY_BITS);
		end else if (op == OP_D4 || op == OP_D6) begin
			hdr_bits = 7'(OPCODE_BITS + ADDR_BITS + D4_DUMMY_BITS);
		end else begin
			hdr_bits = 7'(OPCODE_BITS + ADDR_BITS);
		end
	endfunction

	// Array program and erase opcodes, held back after power-up
	function automatic logic is_prog_erase(input logic [7:0] op);
		is_prog_erase = (op == 8'h81 || op == 8'h82 || op == 8'h83 || op == 8'h85 ||
			op == 8'h86 || op == 8'h88 || op == 8'h89 || op == 8'h50 ||
			op == 8'h58 || op == 8'h59 || op == 8'h7c || op == 8'hc7);
	endfunction

endpackage

// File: hw/sfc_pin_sync.sv
// Purpose: Two-stage synchroniser for the serial pins
// Assumes: Inputs are asynchronous to sys_clk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module sfc_pin_sync #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Pins
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge sys_clk or negedge arst_n) begin
			if (!arst_n) begin
				meta_q[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_q[i] <= async_in[i];
				sync_out[i] <= meta_q[i];
			end
		end
	end

endmodule
`default_nettype wire

// File: hw/sfc_front.sv
// Purpose: Serial command front end of a page-organised serial flash
// Assumes: sck slower than a quarter of sys_clk; pins arrive asynchronously
// Notes: Decodes the header of each frame begun in standby with no write held back and hands out at most one command per frame
`timescale 1ns/1ps
`default_nettype none
module sfc_front
	import sfc_pkg::*;
#(
	parameter int FIRST_WRITE_CYC = FIRST_WRITE_WAIT_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so_o,
	output logic so_oe,
	// Command side
	input wire logic [7:0] status_byte,
	output sfc_cmd_t cmd_q,
	output logic cmd_valid_q,
	// State
	output sfc_mode_t spi_mode_q,
	output logic standby_q,
	output logic write_allowed_q
);

	// ----------------------------------------
	// Pin synchronisation and edges
	// ----------------------------------------
	logic [2:0] pins_s;
	logic cs_s, sck_s, si_s, cs_prev_q, sck_prev_q;
	logic cs_fall, cs_rise, sck_rise, sck_fall;

	// Select goes in inverted so a cleared synchroniser reads as deselected, avoiding a false fall after reset
	sfc_pin_sync #(.WIDTH(3)) u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in({~cs_n, sck, si}),
		.sync_out(pins_s)
	);

	assign cs_s = ~pins_s[2];
	assign sck_s = pins_s[1];
	assign si_s = pins_s[0];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= cs_s;
			sck_prev_q <= sck_s;
		end
	end

	assign cs_fall = cs_prev_q & ~cs_s;
	assign cs_rise = ~cs_prev_q & cs_s;
	assign sck_rise = ~sck_prev_q & sck_s;
	assign sck_fall = sck_prev_q & ~sck_s;

	// ----------------------------------------
	// Power-on hold and first write delay
	// ----------------------------------------
	sfc_state_t state_q;
	logic [11:0] por_cnt_q;
	logic [31:0] wr_cnt_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_cnt_q <= 32'h0;
			write_allowed_q <= 1'b0;
		end else if (!write_allowed_q) begin
			wr_cnt_q <= wr_cnt_q + 32'h1;
			write_allowed_q <= (wr_cnt_q == 32'(FIRST_WRITE_CYC - 1));
		end
	end

	// ----------------------------------------
	// Frame state and header shifter
	// ----------------------------------------
	logic [6:0] bit_cnt_q, bit_n;
	logic [30:0] shreg_q;
	logic [7:0] op_q, cur_op, new_byte;
	logic [23:0] new_addr;
	logic issued_q, pending_q, hdr_done;

	assign bit_n = bit_cnt_q + 7'h1;
	assign new_byte = {shreg_q[6:0], si_s};
	assign new_addr = {shreg_q[22:0], si_s};
	assign cur_op = (bit_n == 7'(OPCODE_BITS)) ? new_byte : op_q;
	assign hdr_done = (state_q == ST_SHIFT) && !cs_rise && sck_rise && !issued_q &&
		(bit_n == hdr_bits(cur_op));

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_POR;
			por_cnt_q <= 12'h0;
			standby_q <= 1'b0;
		end else begin
			case (state_q)
				ST_POR: begin
					// Pins are not looked at while the hold runs
					por_cnt_q <= por_cnt_q + 12'h1;
					if (por_cnt_q == 12'(SUPPLY_TO_SELECT_WAIT_CYC - 1)) begin
						state_q <= ST_STANDBY;
						standby_q <= 1'b1;
					end
				end
				ST_STANDBY: begin
					// A held-back write blocks new frames so it cannot be overtaken
					if (cs_fall && !pending_q) begin
						state_q <= ST_SHIFT;
						standby_q <= 1'b0;
					end
				end
				default: begin
					if (cs_rise) begin
						state_q <= ST_STANDBY;
						standby_q <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_q <= 7'h0;
			shreg_q <= 31'h0;
			op_q <= 8'h0;
			issued_q <= 1'b0;
		end else if (state_q == ST_STANDBY && cs_fall) begin
			bit_cnt_q <= 7'h0;
			issued_q <= 1'b0;
		end else if (state_q == ST_SHIFT && sck_rise && !issued_q) begin
			shreg_q <= {shreg_q[29:0], si_s};
			bit_cnt_q <= bit_n;
			if (bit_n == 7'(OPCODE_BITS)) begin
				op_q <= new_byte;
			end
			if (hdr_done) begin
				issued_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Command hand-out
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_q <= '0;
		end else if (state_q == ST_SHIFT && sck_rise && !issued_q) begin
			if (bit_n == 7'(OPCODE_BITS)) begin
				cmd_q <= '0;
				cmd_q.opcode <= new_byte;
			end else if (bit_n == 7'(OPCODE_BITS + ADDR_BITS) && has_addr(op_q)) begin
				cmd_q.page_number_bits <= new_addr[PAGE_MSB:PAGE_LSB];
				cmd_q.byte_position_bits <= new_addr[POS_MSB:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_valid_q <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			cmd_valid_q <= 1'b0;
			if (pending_q && write_allowed_q) begin
				cmd_valid_q <= 1'b1;
				pending_q <= 1'b0;
			end else if (hdr_done) begin
				if (is_prog_erase(cur_op) && !write_allowed_q) begin
					pending_q <= 1'b1;
				end else begin
					cmd_valid_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Clock mode and serial output
	// ----------------------------------------
	logic [7:0] tx_q;
	logic tx_on;

	assign tx_on = hdr_done && cur_op == OP_D7;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			spi_mode_q <= SFC_MODE3;
		end else if (cs_fall && state_q != ST_POR) begin
			spi_mode_q <= sck_s ? SFC_MODE3 : SFC_MODE0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			so_oe <= 1'b0;
			so_o <= 1'b0;
			tx_q <= 8'h0;
		end else if (state_q != ST_SHIFT || cs_rise) begin
			so_oe <= 1'b0;
		end else if (tx_on) begin
			tx_q <= status_byte;
		end else if (sck_fall && issued_q && op_q == OP_D7) begin
			// Status repeats for as long as the host keeps clocking
			so_oe <= 1'b1;
			so_o <= tx_q[7];
			tx_q <= {tx_q[6:0], tx_q[7]};
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	AST_MODE_RESET: assert property (state_q == ST_POR |-> spi_mode_q == SFC_MODE3)
		else $error("mode not 3 during reset hold");
	AST_SO_IDLE: assert property (state_q != ST_SHIFT |-> !so_oe)
		else $error("output driven outside a frame");
	AST_START_FALL: assert property ((state_q == ST_SHIFT && $past(state_q) == ST_STANDBY) |-> $past(cs_fall))
		else $error("frame began without select fall");
	AST_MODE_SAMPLE: assert property ((cs_fall && state_q != ST_POR) |=> spi_mode_q == sfc_mode_t'($past(sck_s)))
		else $error("mode does not follow idle clock");
	AST_POR_IGNORE: assert property (state_q == ST_POR |-> !cmd_valid_q && !so_oe && !standby_q)
		else $error("activity during power-on hold");
	AST_POR_TO_STANDBY: assert property ((state_q == ST_POR && por_cnt_q == 12'(SUPPLY_TO_SELECT_WAIT_CYC - 1))
		|=> state_q == ST_STANDBY && standby_q)
		else $error("standby not entered after hold");
	AST_WRITE_HOLD: assert property ((cmd_valid_q && is_prog_erase(cmd_q.opcode)) |-> write_allowed_q)
		else $error("write released before delay");
	AST_ADDR_LAYOUT: assert property ((state_q == ST_SHIFT && sck_rise && !issued_q && has_addr(op_q) &&
		bit_cnt_q == 7'(OPCODE_BITS + ADDR_BITS - 1))
		|=> cmd_q.page_number_bits == $past(shreg_q[20:9]) &&
		cmd_q.byte_position_bits == {$past(shreg_q[8:0]), $past(si_s)})
		else $error("address fields misplaced");
	AST_HDR_LEN: assert property ((cmd_valid_q && !$past(pending_q)) |-> bit_cnt_q == hdr_bits(cmd_q.opcode))
		else $error("command issued at wrong bit count");
	AST_MSB_FIRST: assert property ((state_q == ST_SHIFT && sck_rise && !cs_rise && bit_cnt_q == 7'h7)
		|=> op_q[0] == $past(si_s) && op_q[7] == $past(shreg_q[6]))
		else $error("opcode not msb first");

	COV_D2: cover property (cmd_valid_q && cmd_q.opcode == OP_D2);
	COV_STATUS: cover property (so_oe && op_q == OP_D7);
	COV_HELD_WRITE: cover property (pending_q ##1 cmd_valid_q);
	COV_MODE0: cover property (spi_mode_q == SFC_MODE0);

endmodule
`default_nettype wire

// File: verification/sfc_host.sv
// Purpose: Host controller model that frames commands on cs_n, sck and si
// Assumes: sys_clk of 50 MHz; sck half period of four sys_clk cycles
// Notes: outside frames sck only moves to the next frame's idle level before cs_n falls; si toggles when it carries nothing
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
	// Clock
	input wire logic sys_clk,
	// Serial pins
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so_o,
	input wire logic so_oe
);
	logic [7:0] rd;
	logic rd_oe;
	initial begin
		cs_n = 1'b1;
		sck = 1'b1;
		si = 1'b0;
		rd = 8'h00;
		rd_oe = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One frame; extra adds read clocks whose so bits land in rd
	task automatic frame(input logic idle, input logic [63:0] bits, input int n, input int extra);
		sck <= idle;
		rd_oe <= 1'b1;
		tick(4);
		cs_n <= 1'b0;
		tick(4);
		for (int i = n - 1; i >= 0; i--) begin
			sck <= 1'b0;
			si <= bits[i];
			tick(4);
			sck <= 1'b1;
			tick(4);
		end
		for (int i = 0; i < extra; i++) begin
			sck <= 1'b0;
			si <= ~si;
			tick(4);
			sck <= 1'b1;
			tick(4);
			// A released output shows the inverse of its last level
			rd <= {rd[6:0], so_oe ? so_o : ~so_o};
			rd_oe <= rd_oe & so_oe;
		end
		sck <= idle;
		si <= ~si;
		tick(4);
		cs_n <= 1'b1;
		tick(6);
	endtask
endmodule
`default_nettype wire

// File: verification/test_serial_flash_powerup_cmd_frame.sv
// Purpose: Self-checking bench for the serial flash command front end
// Assumes: First write delay shortened to 12000 cycles
// Notes: Every scenario is its own task
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_powerup_cmd_frame;
	import sfc_pkg::*;
	localparam int FW = 12000;
	logic sys_clk, arst_n, cs_n, sck, si, so_o, so_oe, cmd_valid_q, standby_q, write_allowed_q;
	logic [7:0] status_byte;
	sfc_cmd_t cmd_q, cap;
	sfc_mode_t spi_mode_q;
	int errors, cmp_count, vcnt, cyc, tmo;
	sfc_front #(.FIRST_WRITE_CYC(FW)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
		.si(si), .so_o(so_o), .so_oe(so_oe), .status_byte(status_byte), .cmd_q(cmd_q),
		.cmd_valid_q(cmd_valid_q), .spi_mode_q(spi_mode_q), .standby_q(standby_q),
		.write_allowed_q(write_allowed_q));
	sfc_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe(so_oe));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc <= 0;
		end else begin
			cyc <= cyc + 1;
		end
	end
	always @(posedge sys_clk) begin
		tmo <= tmo + 1;
		if (tmo == 60000) begin
			errors++;
			finish_test();
		end
		if (cmd_valid_q === 1'b1) begin
			vcnt <= vcnt + 1;
			cap <= cmd_q;
		end
	end
	task automatic chk1(input logic got, input logic exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h", $time, msg, got);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic t_por();
		chk1(so_oe, 1'b0, "so driven after reset");
		chk1(spi_mode_q, SFC_MODE3, "reset mode");
		host.frame(1'b0, {56'h0, OP_D7}, 8, 8);
		chkv(vcnt, 0, "command taken in hold");
		chk1(host.rd_oe, 1'b0, "so driven in hold");
		chk1(spi_mode_q, SFC_MODE3, "mode sampled in hold");
		for (int i = 0; i < 4000 && standby_q !== 1'b1; i++) @(posedge sys_clk);
		chk1(cyc >= SUPPLY_TO_SELECT_WAIT_CYC && cyc <= SUPPLY_TO_SELECT_WAIT_CYC + 2, 1'b1, "standby time");
		host.tick(4);
	endtask
	task automatic t_d2();
		host.frame(1'b0, {OP_D2, 2'b11, 12'ha5c, 10'h2b3, 32'h0f0f3c3c}, 64, 0);
		chkv(vcnt, 1, "d2 pulses");
		chkv(cap, {OP_D2, 12'ha5c, 10'h2b3}, "d2 fields");
		chk1(spi_mode_q, SFC_MODE0, "mode 0 pick");
	endtask
	task automatic t_lengths();
		logic [7:0] ops[4] = '{OP_D1, OP_D4, OP_D6, OP_D7};
		int lens[4] = '{32, 40, 40, 8};
		logic [63:0] b;
		int v0;
		for (int k = 0; k < 4; k++) begin
			b = {24'h0, ops[k], 2'b11, 12'hfff, 10'h155, 8'h00} >> (40 - lens[k]);
			v0 = vcnt;
			host.frame(1'b1, b >> 1, lens[k] - 1, 0);
			chkv(vcnt, v0, "short header");
			host.frame(1'b1, b, lens[k], 0);
			chkv(vcnt, v0 + 1, "full header");
			chkv(cap.opcode, ops[k], "opcode");
			if (k < 3) chkv(cap.byte_position_bits, 10'h155, "position");
			chk1(spi_mode_q, SFC_MODE3, "mode 3 pick");
		end
	endtask
	task automatic t_status(input logic [7:0] s);
		status_byte <= s;
		host.frame(1'b1, {56'h0, OP_D7}, 8, 8);
		chk1(host.rd_oe, 1'b1, "so not driven");
		chkv(host.rd, s, "status bits");
		chk1(so_oe, 1'b0, "so after frame");
		chk1(standby_q, 1'b1, "standby after frame");
	endtask
	task automatic t_write();
		int v0;
		v0 = vcnt;
		chk1(write_allowed_q, 1'b0, "write early");
		host.frame(1'b1, {32'h0, 8'h82, 2'b00, 12'h123, 10'h0aa}, 32, 0);
		host.frame(1'b0, {56'h0, OP_D7}, 8, 8);
		chkv(vcnt, v0, "write not held");
		chk1(host.rd_oe, 1'b0, "frame during hold");
		chk1(spi_mode_q, SFC_MODE0, "mode during write hold");
		for (int i = 0; i < FW && write_allowed_q !== 1'b1; i++) @(posedge sys_clk);
		chk1(cyc >= FW && cyc <= FW + 2, 1'b1, "write delay");
		host.tick(6);
		chkv(vcnt, v0 + 1, "held write");
		chkv(cap, {8'h82, 12'h123, 10'h0aa}, "held fields");
	endtask
	initial begin
		arst_n = 1'b0;
		status_byte = 8'h00;
		errors = 0;
		cmp_count = 0;
		vcnt = 0;
		tmo = 0;
		cap = '0;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		t_por();
		t_d2();
		t_lengths();
		t_status(8'h5a);
		t_status(8'ha3);
		t_write();
		finish_test();
	end
endmodule
`default_nettype wire
